// [logic/mmi_interp.sv]
// Message interpreter: channel voice, channel mode and system messages.
// Assumes a byte receiver on clk_sys and the raw input pin for thru.
//
// Notes on behaviour
// - Note numbers span 0 to 127; 60 is middle C.
// - Velocity 1 to 127 is dynamics; velocity 0 acts as note off.
// - Omni on accepts all channels; omni off accepts the base channel only.
// - Mono sounds one note at a time; poly uses every free voice.
// - Channel pressure is one value; poly pressure carries a key.
// - Program change picks one of 128 programs.
// - Controllers 32 to 63 are low parts of controllers 0 to 31.
// - Switch controllers such as sustain are two-state: 0 off, 127 on.
// - Controllers 100 and 101 set high and low parameter number parts.
// - Controller 6 sets the parameter; 96 and 97 step it.
// - Controller 121 value 0 restores all controllers to defaults.
// - Controller 122 turns local control off at 0, on at 127.
// - Controller 126 enters mono with count 0 to 16; 127 enters poly.
// - System messages are taken regardless of channel setting.
// - Song position relocates playback to the given sixteenth count.
// - Exclusive data for another maker or product is dropped.
// - Each clock while playing advances song position by one twenty-fourth beat.
// - Start plays from song start; stop halts playback.
// - Continue after stop resumes where playback halted.
// - Thru output copies the input stream exactly.
`timescale 1ns/100ps
module mmi_interp #(
  parameter logic [7:0] NUM_VOICES = 8'h10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic midi_in,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic thru_tx,
  output logic ev_valid,
  output mmi_pkg::mmi_ev_s ev,
  output logic all_off,
  output logic [6:0] program_num,
  output logic sx_valid,
  output logic [7:0] sx_byte,
  output logic tick,
  output logic playing,
  output logic local_on
);
  import mmi_pkg::*;

  logic msg_valid;
  mmi_msg_s msg;
  logic p_sx_begin;
  logic p_sx_data;
  logic p_sx_end;
  logic [7:0] p_sx_byte;
  logic in_meta_q;
  logic in_sync_q;
  logic [3:0] base_ch_q;
  logic omni_q;
  logic mono_q;
  logic [4:0] mono_cnt_q;
  logic [7:0] voices_q;
  logic [6:0] held_q;
  logic held_valid_q;
  logic [16:0] song_pos_q;
  logic [13:0] rpn_q;
  logic [13:0] param_q;
  logic [6:0] ctl_msb_q [32];
  logic [6:0] ctl_lsb_q [32];
  logic [5:0] sw_q;
  logic [4:0] ctl_sel_q;
  logic [6:0] maker_q;
  logic [6:0] product_q;
  mmi_sx_e sx_q;
  logic is_chan;
  logic acc_chan;
  logic acc_sys;
  logic [6:0] cc;
  logic [6:0] cv;
  logic is_cc;
  logic mode_cc;

  mmi_parse u_parse (
    .clk_sys(clk_sys),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .msg_valid(msg_valid),
    .msg(msg),
    .sx_begin(p_sx_begin),
    .sx_data(p_sx_data),
    .sx_end(p_sx_end),
    .sx_byte(p_sx_byte)
  );

  // ----------------------------------------
  // Thru path
  // ----------------------------------------
  // pin copy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_meta_q <= 1'b1;
      in_sync_q <= 1'b1;
      thru_tx <= 1'b1;
    end else begin
      in_meta_q <= midi_in;
      in_sync_q <= in_meta_q;
      thru_tx <= in_sync_q;
    end
  end

  // ----------------------------------------
  // Message acceptance
  // ----------------------------------------
  assign is_chan = msg.status[7:4] != ST_SYSTEM;
  assign acc_chan = msg_valid && is_chan &&
                    (omni_q || msg.status[3:0] == base_ch_q);
  assign acc_sys = msg_valid && !is_chan;
  assign cc = msg.d1;
  assign cv = msg.d2;
  assign is_cc = acc_chan && msg.status[7:4] == ST_CTRL;
  assign mode_cc = is_cc && (cc == CC_MONO || cc == CC_POLY);

  // ----------------------------------------
  // Voice events
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ev_valid <= 1'b0;
      ev <= '0;
      all_off <= 1'b0;
      voices_q <= 8'h00;
      held_q <= NOTE_MIDDLE_C;
      held_valid_q <= 1'b0;
    end else begin
      ev_valid <= 1'b0;
      all_off <= 1'b0;
      ev.chan <= msg.status[3:0];
      ev.note <= msg.d1;
      ev.value <= msg.d2;
      ev.prev_note <= held_q;
      ev.retrig <= 1'b0;
      // all notes off, also on any mono or poly message
      if ((is_cc && cc == CC_ALL_OFF && cv == VAL_OFF) || mode_cc) begin
        ev_valid <= 1'b1;
        ev.kind <= EV_ALL_OFF;
        all_off <= 1'b1;
        voices_q <= 8'h00;
        held_valid_q <= 1'b0;
      end else if (acc_chan) begin
        case (msg.status[7:4])
          ST_NOTE_ON, ST_NOTE_OFF: begin
            if (msg.status[7:4] == ST_NOTE_OFF || cv == 7'h00) begin
              ev_valid <= 1'b1;
              ev.kind <= EV_NOTE_OFF;
              if (mono_q && held_valid_q && held_q == msg.d1) begin
                held_valid_q <= 1'b0;
                voices_q <= 8'h00;
              end else if (!mono_q && voices_q != 8'h00) begin
                voices_q <= voices_q - 8'h01;
              end
            end else if (mono_q) begin
              ev_valid <= 1'b1;
              ev.kind <= EV_NOTE_ON;
              ev.retrig <= held_valid_q;
              held_q <= msg.d1;
              held_valid_q <= 1'b1;
              voices_q <= 8'h01;
            // poly only while a voice is free
            end else if (voices_q < NUM_VOICES) begin
              ev_valid <= 1'b1;
              ev.kind <= EV_NOTE_ON;
              voices_q <= voices_q + 8'h01;
            end
          end
          ST_POLY_PRESS: begin
            ev_valid <= 1'b1;
            ev.kind <= EV_POLY_PRESS;
          end
          ST_CHAN_PRESS: begin
            ev_valid <= 1'b1;
            ev.kind <= EV_CHAN_PRESS;
            ev.note <= 7'h00;
            ev.value <= msg.d1;
          end
          ST_BEND: begin
            ev_valid <= 1'b1;
            ev.kind <= EV_BEND;
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      program_num <= 7'h00;
    end else if (acc_chan && msg.status[7:4] == ST_PROG) begin
      program_num <= msg.d1;
    end
  end

  // ----------------------------------------
  // Channel mode
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      omni_q <= RST_OMNI;
      mono_q <= 1'b0;
      mono_cnt_q <= 5'h00;
      local_on <= RST_LOCAL;
    end else if (is_cc) begin
      // only the two defined values act
      if (cc == CC_LOCAL && cv == VAL_OFF) begin
        local_on <= 1'b0;
      end else if (cc == CC_LOCAL && cv == VAL_ON) begin
        local_on <= 1'b1;
      end
      if (cc == CC_OMNI_OFF) begin
        omni_q <= 1'b0;
      end else if (cc == CC_OMNI_ON) begin
        omni_q <= 1'b1;
      end
      if (cc == CC_MONO && {1'b0, cv} <= {3'h0, MONO_CNT_MAX}) begin
        mono_q <= 1'b1;
        mono_cnt_q <= cv[4:0];
        if (cv == 7'h00) begin
          omni_q <= 1'b0;
        end
      end else if (cc == CC_POLY) begin
        mono_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Controllers and parameters
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        ctl_msb_q[i] <= 7'h00;
        ctl_lsb_q[i] <= 7'h00;
      end
      sw_q <= 6'h00;
      rpn_q <= RPN_NULL;
      param_q <= 14'h0000;
    end else if (is_cc && cc == CC_RESET_ALL && cv == VAL_OFF) begin
      for (int i = 0; i < 32; i++) begin
        ctl_msb_q[i] <= 7'h00;
        ctl_lsb_q[i] <= 7'h00;
      end
      sw_q <= 6'h00;
      rpn_q <= RPN_NULL;
    end else if (is_cc) begin
      // low parts pair with 0 to 31
      if (cc < CC_LSB_FIRST) begin
        ctl_msb_q[cc[4:0]] <= cv;
      end else if (cc < CC_SW_FIRST) begin
        ctl_lsb_q[cc[4:0]] <= cv;
      end else if (cc <= CC_SW_LAST) begin
        sw_q[cc[2:0]] <= (cv == VAL_ON);
      end
      if (cc == CC_RPN_HIGH) begin
        rpn_q[13:7] <= cv;
      end else if (cc == CC_RPN_LOW) begin
        rpn_q[6:0] <= cv;
      end
      // data entry on the selected parameter
      if (rpn_q != RPN_NULL) begin
        if (cc == CC_DATA_MSB) begin
          param_q[13:7] <= cv;
        end else if (cc == CC_DATA_LSB) begin
          param_q[6:0] <= cv;
        end else if (cc == CC_DATA_INC && param_q != PARAM_MAX) begin
          param_q <= param_q + 14'h0001;
        end else if (cc == CC_DATA_DEC && param_q != 14'h0000) begin
          param_q <= param_q - 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Song position and transport
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      song_pos_q <= 17'h00000;
      playing <= 1'b0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (acc_sys) begin
        case (msg.status)
          SYS_SONG_POS: begin
            song_pos_q <= {3'h0, msg.d2, msg.d1} * CLK_PER_BEAT;
          end
          SYS_START: begin
            song_pos_q <= 17'h00000;
            playing <= 1'b1;
          end
          SYS_STOP: begin
            playing <= 1'b0;
          end
          SYS_CONT: begin
            playing <= 1'b1;
          end
          SYS_CLOCK: begin
            if (playing) begin
              song_pos_q <= song_pos_q + 17'h00001;
              tick <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Exclusive filter
  // ----------------------------------------
  // identity match before passing data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sx_q <= SX_IDLE;
      sx_valid <= 1'b0;
      sx_byte <= 8'h00;
    end else begin
      sx_valid <= 1'b0;
      if (p_sx_begin) begin
        sx_q <= SX_MAKER;
      end else if (p_sx_end) begin
        sx_q <= SX_IDLE;
      end else if (p_sx_data) begin
        case (sx_q)
          SX_MAKER: begin
            sx_q <= (p_sx_byte[6:0] == maker_q) ? SX_PRODUCT : SX_DROP;
          end
          SX_PRODUCT: begin
            sx_q <= (p_sx_byte[6:0] == product_q) ? SX_PASS : SX_DROP;
          end
          SX_PASS: begin
            sx_valid <= 1'b1;
            sx_byte <= p_sx_byte;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      base_ch_q <= RST_BASE_CH;
      ctl_sel_q <= 5'h00;
      maker_q <= RST_MAKER;
      product_q <= RST_PRODUCT;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: base_ch_q <= reg_wdata[3:0];
        REG_CTL_SEL: ctl_sel_q <= reg_wdata[4:0];
        REG_ID: begin
          maker_q <= reg_wdata[6:0];
          product_q <= reg_wdata[14:8];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data lives one cycle only, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {28'h0, base_ch_q};
        REG_MODE: reg_rdata <= {23'h0, playing, mono_cnt_q, local_on,
                                mono_q, omni_q};
        REG_PROG: reg_rdata <= {25'h0, program_num};
        REG_SONG: reg_rdata <= {15'h0, song_pos_q};
        REG_PARAM: reg_rdata <= {4'h0, param_q, rpn_q};
        REG_CTL_SEL: reg_rdata <= {27'h0, ctl_sel_q};
        REG_CTL_VAL: reg_rdata <= {10'h0, sw_q, 2'h0,
                                   ctl_msb_q[ctl_sel_q],
                                   ctl_lsb_q[ctl_sel_q]};
        REG_VOICES: reg_rdata <= {15'h0, held_valid_q, held_q, 1'b0,
                                  voices_q};
        REG_ID: reg_rdata <= {17'h0, product_q, 1'b0, maker_q};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_note_zero;
    acc_chan && msg.status[7:4] == ST_NOTE_ON && cv == 7'h00;
  endsequence
  sequence s_foreign;
    msg_valid && is_chan && !omni_q && msg.status[3:0] != base_ch_q;
  endsequence
  sequence s_sys(logic [7:0] b);
    acc_sys && msg.status == b;
  endsequence

  chk_vel_zero_off: assert property (s_note_zero |=>
    ev_valid && ev.kind == EV_NOTE_OFF) else $error("velocity 0 not off");
  chk_omni_filter: assert property (s_foreign |=> !ev_valid)
    else $error("foreign channel accepted");
  chk_mono_single: assert property (mono_q && !mode_cc |=>
    voices_q <= 8'h01) else $error("mono holds several voices");
  chk_prog_take: assert property (acc_chan &&
    msg.status[7:4] == ST_PROG |=> program_num == $past(msg.d1))
    else $error("program not taken");
  chk_reset_ctrl: assert property (is_cc && cc == CC_RESET_ALL &&
    cv == VAL_OFF |=> rpn_q == RPN_NULL && sw_q == 6'h00)
    else $error("controllers not reset");
  chk_local_ctl: assert property (is_cc && cc == CC_LOCAL &&
    cv == VAL_OFF |=> !local_on) else $error("local stays on");
  chk_start_pos: assert property (s_sys(SYS_START) |=>
    song_pos_q == 17'h00000 && playing) else $error("start not at zero");
  chk_continue_pos: assert property (s_sys(SYS_CONT) |=>
    playing && $stable(song_pos_q)) else $error("continue moved position");
  chk_clock_step: assert property (s_sys(SYS_CLOCK) ##0 playing |=>
    song_pos_q == $past(song_pos_q) + 17'h00001 && tick)
    else $error("clock did not advance");
  chk_thru_copy: assert property (thru_tx == $past(midi_in, 3))
    else $error("thru differs from input");

endmodule

// [logic/mmi_parse.sv]
// Byte assembler: status, running status, real-time and exclusive bytes.
// Assumes received bytes arrive as one-cycle strobes on clk_sys.
`timescale 1ns/100ps
module mmi_parse (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic msg_valid,
  output mmi_pkg::mmi_msg_s msg,
  output logic sx_begin,
  output logic sx_data,
  output logic sx_end,
  output logic [7:0] sx_byte
);
  import mmi_pkg::*;

  logic [7:0] status_q;
  logic [6:0] d1_q;
  logic cnt_q;
  logic in_sx_q;

  // Data bytes each status expects
  function automatic logic [1:0] data_len(input logic [7:0] st);
    logic [1:0] n;
    n = 2'h2;
    if (st[7:4] == ST_PROG || st[7:4] == ST_CHAN_PRESS) begin
      n = 2'h1;
    end else if (st == SYS_TIMECODE || st == SYS_SONG_SEL) begin
      n = 2'h1;
    end else if (st[7:4] == ST_SYSTEM && st != SYS_SONG_POS) begin
      n = 2'h0;
    end
    return n;
  endfunction

  // ----------------------------------------
  // Assembly
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_q <= 8'h00;
      d1_q <= 7'h00;
      cnt_q <= 1'b0;
      in_sx_q <= 1'b0;
      msg_valid <= 1'b0;
      msg <= '0;
      sx_begin <= 1'b0;
      sx_data <= 1'b0;
      sx_end <= 1'b0;
      sx_byte <= 8'h00;
    end else begin
      msg_valid <= 1'b0;
      sx_begin <= 1'b0;
      sx_data <= 1'b0;
      sx_end <= 1'b0;
      if (rx_valid && rx_byte >= SYS_REALTIME) begin
        // Real-time bytes slip in anywhere and keep running status
        msg_valid <= 1'b1;
        msg <= '{status: rx_byte, d1: 7'h00, d2: 7'h00};
      end else if (rx_valid && rx_byte[7]) begin
        sx_end <= in_sx_q;
        sx_begin <= (rx_byte == SYS_EX);
        in_sx_q <= (rx_byte == SYS_EX);
        cnt_q <= 1'b0;
        if (data_len(rx_byte) == 2'h0) begin
          status_q <= 8'h00;
          if (rx_byte != SYS_EX && rx_byte != SYS_EX_END) begin
            msg_valid <= 1'b1;
            msg <= '{status: rx_byte, d1: 7'h00, d2: 7'h00};
          end
        end else begin
          status_q <= rx_byte;
        end
      end else if (rx_valid && in_sx_q) begin
        sx_data <= 1'b1;
        sx_byte <= rx_byte;
      end else if (rx_valid && status_q != 8'h00) begin
        if (!cnt_q && data_len(status_q) == 2'h1) begin
          msg_valid <= 1'b1;
          msg <= '{status: status_q, d1: rx_byte[6:0], d2: 7'h00};
        end else if (!cnt_q) begin
          d1_q <= rx_byte[6:0];
          cnt_q <= 1'b1;
        end else begin
          msg_valid <= 1'b1;
          msg <= '{status: status_q, d1: d1_q, d2: rx_byte[6:0]};
          cnt_q <= 1'b0;
        end
        // System common has no running status
        if (status_q[7:4] == ST_SYSTEM && (cnt_q || data_len(status_q) ==
            2'h1)) begin
          status_q <= 8'h00;
        end
      end
    end
  end

endmodule

// [logic/mmi_pkg.sv]
// Shared constants and types of the message interpreter.
// Assumes one system clock; the byte receiver lives outside.
package mmi_pkg;

  // ----------------------------------------
  // Status bytes
  // ----------------------------------------
  localparam logic [3:0] ST_NOTE_OFF = 4'h8;
  localparam logic [3:0] ST_NOTE_ON = 4'h9;
  localparam logic [3:0] ST_POLY_PRESS = 4'ha;
  localparam logic [3:0] ST_CTRL = 4'hb;
  localparam logic [3:0] ST_PROG = 4'hc;
  localparam logic [3:0] ST_CHAN_PRESS = 4'hd;
  localparam logic [3:0] ST_BEND = 4'he;
  localparam logic [3:0] ST_SYSTEM = 4'hf;
  localparam logic [7:0] SYS_EX = 8'hf0;
  localparam logic [7:0] SYS_TIMECODE = 8'hf1;
  localparam logic [7:0] SYS_SONG_POS = 8'hf2;
  localparam logic [7:0] SYS_SONG_SEL = 8'hf3;
  localparam logic [7:0] SYS_EX_END = 8'hf7;
  localparam logic [7:0] SYS_REALTIME = 8'hf8;
  localparam logic [7:0] SYS_CLOCK = 8'hf8;
  localparam logic [7:0] SYS_START = 8'hfa;
  localparam logic [7:0] SYS_CONT = 8'hfb;
  localparam logic [7:0] SYS_STOP = 8'hfc;

  // ----------------------------------------
  // Controller numbers and values
  // ----------------------------------------
  localparam logic [6:0] CC_DATA_MSB = 7'h06;
  localparam logic [6:0] CC_DATA_LSB = 7'h26;
  localparam logic [6:0] CC_LSB_FIRST = 7'h20;
  localparam logic [6:0] CC_SW_FIRST = 7'h40;
  localparam logic [6:0] CC_SW_LAST = 7'h45;
  localparam logic [6:0] CC_DATA_INC = 7'h60;
  localparam logic [6:0] CC_DATA_DEC = 7'h61;
  localparam logic [6:0] CC_RPN_HIGH = 7'h64;
  localparam logic [6:0] CC_RPN_LOW = 7'h65;
  localparam logic [6:0] CC_RESET_ALL = 7'h79;
  localparam logic [6:0] CC_LOCAL = 7'h7a;
  localparam logic [6:0] CC_ALL_OFF = 7'h7b;
  localparam logic [6:0] CC_OMNI_OFF = 7'h7c;
  localparam logic [6:0] CC_OMNI_ON = 7'h7d;
  localparam logic [6:0] CC_MONO = 7'h7e;
  localparam logic [6:0] CC_POLY = 7'h7f;
  localparam logic [6:0] VAL_OFF = 7'h00;
  localparam logic [6:0] VAL_ON = 7'h7f;
  localparam logic [6:0] NOTE_MIDDLE_C = 7'h3c;
  localparam logic [4:0] MONO_CNT_MAX = 5'h10;
  localparam logic [13:0] RPN_NULL = 14'h3fff;
  localparam logic [13:0] PARAM_MAX = 14'h3fff;
  localparam logic [16:0] CLK_PER_BEAT = 17'h00006;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_PROG = 8'h08;
  localparam logic [7:0] REG_SONG = 8'h0c;
  localparam logic [7:0] REG_PARAM = 8'h10;
  localparam logic [7:0] REG_CTL_SEL = 8'h14;
  localparam logic [7:0] REG_CTL_VAL = 8'h18;
  localparam logic [7:0] REG_VOICES = 8'h1c;
  localparam logic [7:0] REG_ID = 8'h20;
  localparam logic [3:0] RST_BASE_CH = 4'h0;
  localparam logic RST_OMNI = 1'b0;
  localparam logic RST_LOCAL = 1'b1;
  // Arbitrary identity values
  localparam logic [6:0] RST_MAKER = 7'h2a;
  localparam logic [6:0] RST_PRODUCT = 7'h15;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    EV_NOTE_OFF = 3'b000,
    EV_NOTE_ON = 3'b001,
    EV_POLY_PRESS = 3'b010,
    EV_CHAN_PRESS = 3'b011,
    EV_BEND = 3'b100,
    EV_ALL_OFF = 3'b101
  } mmi_ev_e;

  typedef enum logic [2:0] {
    SX_IDLE = 3'b000,
    SX_MAKER = 3'b001,
    SX_PRODUCT = 3'b010,
    SX_PASS = 3'b011,
    SX_DROP = 3'b100
  } mmi_sx_e;

  typedef struct packed {
    logic [7:0] status;
    logic [6:0] d1;
    logic [6:0] d2;
  } mmi_msg_s;

  typedef struct packed {
    mmi_ev_e kind;
    logic [3:0] chan;
    logic [6:0] note;
    logic [6:0] value;
    logic [6:0] prev_note;
    logic retrig;
  } mmi_ev_s;

endpackage

// [test/midi_message_interpreter_bench.sv]
// Bench of the interpreter: byte stream, registers and thru.
// Assumes the package and the sequencer model are compiled first.
`timescale 1ns/100ps
module midi_message_interpreter_bench;
  import mmi_pkg::*;
  logic clk_sys, rst, midi_in, rx_valid, reg_wr, reg_rd, ev_valid;
  logic all_off, thru_tx, sx_valid, tick, playing, local_on;
  logic [7:0] rx_byte, reg_addr, sx_byte;
  logic [31:0] reg_wdata, reg_rdata;
  logic [6:0] program_num, nt, vl, pg;
  logic [13:0] bt;
  logic [2:0] hist;
  logic [20:0] e;
  logic [20:0] exp_q[$];
  mmi_ev_s ev;
  int num_errors, checks, ticks, cyc;
  mmi_interp mmi_interp_inst (.clk_sys, .rst, .midi_in, .rx_valid,
    .rx_byte, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .thru_tx, .ev_valid, .ev, .all_off, .program_num, .sx_valid,
    .sx_byte, .tick, .playing, .local_on);
  mmi_host_model mmi_host_model_inst (.clk_sys, .rx_valid, .rx_byte);
  task automatic chk(input string nm, input logic [31:0] x, y);
    checks++;
    if (y !== x) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg", x, reg_rdata);
    @(posedge clk_sys);
  endtask
  task automatic tx(input logic [7:0] b0, b1, b2, input int n);
    mmi_host_model_inst.send(b0, b1, b2, n);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Pin stimulus, thru history and hang limit
  always @(posedge clk_sys) begin
    midi_in <= rst ? 1'b1 : 1'($urandom_range(1));
    hist <= {hist[1:0], midi_in};
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  // Result watcher looks mid-cycle, after outputs have settled
  always @(negedge clk_sys) begin
    if (!rst) begin
      chk("thru", 32'(hist[2]), 32'(thru_tx));
      if (ev_valid === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
        chk("ev", 32'(e), 32'({ev.kind, ev.chan, ev.note, ev.value}));
        chk("all_off", 32'(e[20:18] == EV_ALL_OFF), 32'(all_off));
      end
      if (sx_valid === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
        chk("exclusive", 32'(e), 32'(sx_byte));
      end
      if (tick === 1'b1) ticks++;
    end
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h4f02));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h40, 32'h0);
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL, 32'h3);
    nt = 7'($urandom_range(127));
    vl = 7'($urandom_range(127, 1));
    pg = 7'($urandom_range(127));
    exp_q.push_back({EV_NOTE_ON, 4'h3, nt, vl});
    tx(8'h93, {1'b0, nt}, {1'b0, vl}, 3);
    exp_q.push_back({EV_NOTE_OFF, 4'h3, nt, 7'h00});
    tx(8'h93, {1'b0, nt}, 8'h00, 3);
    tx(8'h95, 8'h3c, 8'h40, 3);
    tx(8'hb3, 8'h7d, 8'h00, 3);
    exp_q.push_back({EV_NOTE_ON, 4'h5, NOTE_MIDDLE_C, 7'h40});
    tx(8'h95, 8'h3c, 8'h40, 3);
    tx(8'hc3, {1'b0, pg}, 8'h00, 2);
    chk("program", 32'(pg), 32'(program_num));
    tx(8'hb3, 8'h7a, 8'h00, 3);
    chk("local", 32'h0, 32'(local_on));
    tx(8'hb3, 8'h40, 8'h7f, 3);
    rd(REG_CTL_VAL, 32'h10000);
    tx(8'hb3, 8'h79, 8'h00, 3);
    rd(REG_CTL_VAL, 32'h0);
    tx(8'hb3, 8'h64, 8'h00, 3);
    tx(8'h65, 8'h00, 8'h00, 2);
    tx(8'h06, 8'h05, 8'h00, 2);
    tx(8'h60, 8'h00, 8'h00, 2);
    rd(REG_PARAM, 32'h00a04000);
    exp_q.push_back({EV_POLY_PRESS, 4'h3, NOTE_MIDDLE_C, 7'h11});
    tx(8'ha3, 8'h3c, 8'h11, 3);
    exp_q.push_back({EV_CHAN_PRESS, 4'h3, 7'h00, 7'h22});
    tx(8'hd3, 8'h22, 8'h00, 2);
    exp_q.push_back({EV_ALL_OFF, 4'h3, CC_MONO, 7'h01});
    tx(8'hb3, 8'h7e, 8'h01, 3);
    exp_q.push_back({EV_NOTE_ON, 4'h3, nt, vl});
    tx(8'h93, {1'b0, nt}, {1'b0, vl}, 3);
    exp_q.push_back({EV_NOTE_ON, 4'h3, NOTE_MIDDLE_C, 7'h40});
    tx(8'h93, 8'h3c, 8'h40, 3);
    rd(REG_VOICES, 32'h00017801);
    exp_q.push_back({EV_ALL_OFF, 4'h3, CC_ALL_OFF, VAL_OFF});
    tx(8'hb3, 8'h7b, 8'h00, 3);
    rd(REG_VOICES, 32'h00007800);
    exp_q.push_back({EV_ALL_OFF, 4'h3, CC_POLY, VAL_OFF});
    tx(8'hb3, 8'h7f, 8'h00, 3);
    rd(REG_MODE, 32'h00000009);
    exp_q.push_back({13'h0, 1'b0, nt});
    tx(SYS_EX, {1'b0, RST_MAKER}, {1'b0, RST_PRODUCT}, 3);
    tx({1'b0, nt}, SYS_EX_END, 8'h00, 2);
    tx(SYS_EX, 8'h00, {1'b0, RST_PRODUCT}, 3);
    tx({1'b0, vl}, SYS_EX_END, 8'h00, 2);
    tx(SYS_START, 8'h00, 8'h00, 1);
    mmi_host_model_inst.beat();
    chk("ticks", 32'd24, 32'(ticks));
    rd(REG_SONG, 32'd24);
    tx(SYS_STOP, 8'h00, 8'h00, 1);
    chk("playing", 32'h0, 32'(playing));
    mmi_host_model_inst.beat();
    chk("ticks", 32'd24, 32'(ticks));
    bt = 14'($urandom_range(16383));
    tx(SYS_SONG_POS, {1'b0, bt[6:0]}, {1'b0, bt[13:7]}, 3);
    rd(REG_SONG, 32'(bt) * 6);
    tx(SYS_CONT, 8'h00, 8'h00, 1);
    tx(SYS_CLOCK, 8'h00, 8'h00, 1);
    rd(REG_SONG, 32'(bt) * 6 + 1);
    tx(SYS_START, 8'h00, 8'h00, 1);
    rd(REG_SONG, 32'h0);
    chk("pending", 32'h0, 32'(exp_q.size()));
    results();
  end
endmodule

// [test/mmi_host_model.sv]
// Sequencer model feeding the byte side of the interpreter.
// Assumes one byte per clk_sys cycle at most, bus released after.
`timescale 1ns/100ps
module mmi_host_model (
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  import mmi_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Released bus inverted so stale bytes never look valid
  task automatic send(input logic [7:0] b0, b1, b2, input int n);
    logic [7:0] m[3];
    m = '{b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= m[i];
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic beat();
    repeat (24) send(SYS_CLOCK, 8'h00, 8'h00, 1);
  endtask
endmodule
